// *** verilog/tpio_pkg.sv ***
// Behaviour
// - pin drives 0 after reset until configured
// - clear code: initial level, low on match
// - set code: initial level, high on match
// - toggle code: initial level, invert on match
// - capture code x00: capture on rising edge
// - capture code x01: capture on falling edge
// - capture code x1x: capture both edges
// - channel 0 code 11xx: capture on ch1 count
// - buffer mode: io setting ignored, no events
// - buffer transfer setting: 8-bit read/write, one
// - bits 7 to 2 read as zero
// - two-bit transfer enable field, reset 00
package tpio_pkg;
	// register byte offsets, low address byte only
	localparam logic [7:0] OFF_IO_CTRL = 8'h00;
	localparam logic [7:0] OFF_MODE = 8'h04;
	localparam logic [7:0] OFF_XFER = 8'h08;
	localparam logic [7:0] OFF_GEN_D0 = 8'h0C;
	localparam logic [7:0] OFF_GEN_C3 = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam int ADDR_W = 8;
	// reset values and write masks
	localparam logic [7:0] IO_CTRL_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] MODE_MASK = 8'h03;
	localparam logic [7:0] XFER_RST = 8'h00;
	localparam logic [7:0] XFER_MASK = 8'h03;
	localparam int XFER_W = 2;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	// field layout
	localparam int NUM_CH = 2;
	localparam int FLD_W = 4;
	localparam int CH0_FLD_LSB = 0;
	localparam int CH3_FLD_LSB = 4;
	localparam int MODE_BUF_B_BIT = 0;
	localparam int MODE_BUF_A_BIT = 1;
	localparam int IO_DIR_BIT = 3;
	localparam int IO_LVL_BIT = 2;
	// compare actions, capture edges and source code
	localparam logic [1:0] ACT_RETAIN = 2'h0;
	localparam logic [1:0] ACT_CLEAR = 2'h1;
	localparam logic [1:0] ACT_SET = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] SRC_CH1 = 2'h3;
	// bus
	localparam int HTRANS_ACT_BIT = 1;
	localparam logic HRESP_OKAY = 1'b0;
endpackage

// *** verilog/tpio_chan.sv ***
`timescale 1ns/1ps
module tpio_chan #(
	parameter bit HAS_CH1_SRC = 1'b0
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// configuration
	input wire logic [3:0] io_sel,
	input wire logic io_load,
	input wire logic buf_mode,
	// timer events
	input wire logic cmp_match,
	input wire logic ch1_count,
	// pin
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_n,
	// capture event, same cycle as the edge
	output logic cap_hit
);
	logic pin_prev_reg;
	logic rise;
	logic fall;
	logic is_cap;
	logic ch1_src;
	logic [1:0] act;

	assign is_cap = io_sel[tpio_pkg::IO_DIR_BIT];
	assign ch1_src = HAS_CH1_SRC &&
		(io_sel[3:2] == tpio_pkg::SRC_CH1);
	assign act = io_sel[1:0];
	assign rise = pin_in & ~pin_prev_reg;
	assign fall = ~pin_in & pin_prev_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_prev_reg <= 1'b0;
		end else begin
			pin_prev_reg <= pin_in;
		end
	end

	// io_sel bit 2 is don't-care for capture unless ch1 source applies
	always_comb begin
		cap_hit = 1'b0;
		if (!buf_mode && is_cap) begin
			if (ch1_src) begin
				cap_hit = ch1_count;
			end else if (act == tpio_pkg::EDGE_RISE) begin
				cap_hit = rise;
			end else if (act == tpio_pkg::EDGE_FALL) begin
				cap_hit = fall;
			end else begin
				cap_hit = rise | fall;
			end
		end
	end

	// pin level; retain codes keep the level held at load time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_out <= 1'b0;
		end else if (buf_mode) begin
			pin_out <= pin_out;
		end else if (io_load) begin
			if (!is_cap && act != tpio_pkg::ACT_RETAIN) begin
				pin_out <= io_sel[tpio_pkg::IO_LVL_BIT];
			end
		end else if (!is_cap && cmp_match) begin
			unique case (act)
				tpio_pkg::ACT_RETAIN: pin_out <= pin_out;
				tpio_pkg::ACT_CLEAR: pin_out <= 1'b0;
				tpio_pkg::ACT_SET: pin_out <= 1'b1;
				tpio_pkg::ACT_TOGGLE: pin_out <= ~pin_out;
			endcase
		end
	end

	// capture releases the pin so the outside can drive it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_oe_n <= 1'b0;
		end else if (io_load && !buf_mode) begin
			pin_oe_n <= is_cap;
		end
	end

	logic loaded_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			loaded_reg <= 1'b0;
		end else if (io_load) begin
			loaded_reg <= 1'b1;
		end
	end

	a_reset_low: assert property (@(posedge hclk) disable iff (!hresetn)
		!loaded_reg |-> (pin_out == 1'b0 && pin_oe_n == 1'b0))
		else $error("pin not driven low before configuration");
	a_clear_match: assert property (@(posedge hclk) disable iff (!hresetn)
		(!buf_mode && !io_load && io_sel[3] == 1'b0 &&
		act == tpio_pkg::ACT_CLEAR && cmp_match) |=> !pin_out)
		else $error("clear on match failed");
	a_set_match: assert property (@(posedge hclk) disable iff (!hresetn)
		(!buf_mode && !io_load && io_sel[3] == 1'b0 &&
		act == tpio_pkg::ACT_SET && cmp_match) |=> pin_out)
		else $error("set on match failed");
	a_toggle_match: assert property (@(posedge hclk) disable iff (!hresetn)
		(!buf_mode && !io_load && io_sel[3] == 1'b0 &&
		act == tpio_pkg::ACT_TOGGLE && cmp_match)
		|=> pin_out != $past(pin_out))
		else $error("toggle on match failed");
	a_init_level: assert property (@(posedge hclk) disable iff (!hresetn)
		(io_load && !buf_mode && io_sel[3] == 1'b0 &&
		act != tpio_pkg::ACT_RETAIN)
		|=> pin_out == $past(io_sel[2]))
		else $error("initial level wrong");
	a_rise_cap: assert property (@(posedge hclk) disable iff (!hresetn)
		(!buf_mode && io_sel[3] && !ch1_src && act == 2'h0)
		|-> cap_hit == (pin_in && !$past(pin_in)))
		else $error("rising capture wrong");
	a_fall_cap: assert property (@(posedge hclk) disable iff (!hresetn)
		(!buf_mode && io_sel[3] && !ch1_src && act == 2'h1)
		|-> cap_hit == (!pin_in && $past(pin_in)))
		else $error("falling capture wrong");
	a_both_cap: assert property (@(posedge hclk) disable iff (!hresetn)
		(!buf_mode && io_sel[3] && !ch1_src && act[1])
		|-> cap_hit == (pin_in != $past(pin_in)))
		else $error("both-edge capture wrong");
	a_buf_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		buf_mode |-> !cap_hit ##1 $stable(pin_out))
		else $error("event while in buffer mode");
	c_toggle: cover property (@(posedge hclk) disable iff (!hresetn)
		!io_sel[3] && act == tpio_pkg::ACT_TOGGLE && cmp_match);
	c_both: cover property (@(posedge hclk) disable iff (!hresetn)
		io_sel[3] && act[1] && cap_hit);
endmodule

// *** verilog/tpio_top.sv ***
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module tpio_top #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// timer counters and compare events
	input wire logic [CNT_W-1:0] counter_ch0,
	input wire logic [CNT_W-1:0] counter_ch3,
	input wire logic cmp_match_ch0_d,
	input wire logic cmp_match_ch3_c,
	input wire logic counter_ch1_tick,
	// pin timer_pin_ch0_d
	input wire logic timer_pin_ch0_d_in,
	output logic timer_pin_ch0_d_out,
	output logic timer_pin_ch0_d_oe_n,
	// pin timer_pin_ch3_c
	input wire logic timer_pin_ch3_c_in,
	output logic timer_pin_ch3_c_out,
	output logic timer_pin_ch3_c_oe_n,
	// complementary pwm transfer control
	output logic [1:0] transfer_enable_field
);
	// software registers
	logic [7:0] timer_io_control_reg;
	logic [7:0] timer_io_control_next;
	logic [7:0] timer_mode_reg;
	logic [7:0] timer_mode_next;
	logic [7:0] buffer_transfer_setting_reg;
	logic [7:0] buffer_transfer_setting_next;
	logic [CNT_W-1:0] general_reg_d_ch0_reg;
	logic [CNT_W-1:0] general_reg_d_ch0_next;
	logic [CNT_W-1:0] general_reg_c_ch3_reg;
	logic [CNT_W-1:0] general_reg_c_ch3_next;

	// bus pipeline
	logic addr_ok;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] rd_val;
	logic wr_io;
	logic wr_mode;
	logic wr_xfer;
	logic wr_gen_d0;
	logic wr_gen_c3;

	// per-channel wiring
	logic [3:0] chan_sel [tpio_pkg::NUM_CH];
	logic [tpio_pkg::NUM_CH-1:0] chan_buf;
	logic [tpio_pkg::NUM_CH-1:0] chan_match;
	logic [tpio_pkg::NUM_CH-1:0] chan_pin_in;
	logic [tpio_pkg::NUM_CH-1:0] chan_pin_out;
	logic [tpio_pkg::NUM_CH-1:0] chan_oe_n;
	logic [tpio_pkg::NUM_CH-1:0] chan_cap;
	logic [tpio_pkg::NUM_CH-1:0] chan_ch1;

	// only whole-word transfers exist, so hsize is not decoded
	assign addr_ok = hsel & htrans[tpio_pkg::HTRANS_ACT_BIT] & hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
		end else if (hready) begin
			wr_pend_reg <= addr_ok & hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_addr_reg <= 8'h00;
		end else if (addr_ok) begin
			wr_addr_reg <= haddr[tpio_pkg::ADDR_W-1:0];
		end
	end

	assign wr_io = wr_pend_reg && wr_addr_reg == tpio_pkg::OFF_IO_CTRL;
	assign wr_mode = wr_pend_reg && wr_addr_reg == tpio_pkg::OFF_MODE;
	assign wr_xfer = wr_pend_reg && wr_addr_reg == tpio_pkg::OFF_XFER;
	assign wr_gen_d0 = wr_pend_reg && wr_addr_reg == tpio_pkg::OFF_GEN_D0;
	assign wr_gen_c3 = wr_pend_reg && wr_addr_reg == tpio_pkg::OFF_GEN_C3;

	// next values fold in the data-phase write, so a read right
	// behind a write returns the new value without a wait state
	always_comb begin
		timer_io_control_next = timer_io_control_reg;
		if (wr_io) begin
			timer_io_control_next = hwdata[7:0];
		end
	end

	always_comb begin
		timer_mode_next = timer_mode_reg;
		if (wr_mode) begin
			timer_mode_next = hwdata[7:0] & tpio_pkg::MODE_MASK;
		end
	end

	always_comb begin
		buffer_transfer_setting_next = buffer_transfer_setting_reg;
		if (wr_xfer) begin
			buffer_transfer_setting_next = hwdata[7:0] & tpio_pkg::XFER_MASK;
		end
	end

	// a capture in the same cycle as a software write wins
	always_comb begin
		general_reg_d_ch0_next = general_reg_d_ch0_reg;
		if (chan_cap[0]) begin
			general_reg_d_ch0_next = counter_ch0;
		end else if (wr_gen_d0) begin
			general_reg_d_ch0_next = hwdata[CNT_W-1:0];
		end
	end

	always_comb begin
		general_reg_c_ch3_next = general_reg_c_ch3_reg;
		if (chan_cap[1]) begin
			general_reg_c_ch3_next = counter_ch3;
		end else if (wr_gen_c3) begin
			general_reg_c_ch3_next = hwdata[CNT_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_io_control_reg <= tpio_pkg::IO_CTRL_RST;
		end else begin
			timer_io_control_reg <= timer_io_control_next;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_mode_reg <= tpio_pkg::MODE_RST;
		end else begin
			timer_mode_reg <= timer_mode_next;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			buffer_transfer_setting_reg <= tpio_pkg::XFER_RST;
		end else begin
			buffer_transfer_setting_reg <= buffer_transfer_setting_next;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			general_reg_d_ch0_reg <= '0;
			general_reg_c_ch3_reg <= '0;
		end else begin
			general_reg_d_ch0_reg <= general_reg_d_ch0_next;
			general_reg_c_ch3_reg <= general_reg_c_ch3_next;
		end
	end

	assign transfer_enable_field =
		buffer_transfer_setting_reg[tpio_pkg::XFER_W-1:0];

	// read mux; unmapped offsets read zero
	always_comb begin
		rd_val = tpio_pkg::RD_ZERO;
		unique case (haddr[tpio_pkg::ADDR_W-1:0])
			tpio_pkg::OFF_IO_CTRL: rd_val[7:0] = timer_io_control_next;
			tpio_pkg::OFF_MODE: rd_val[7:0] = timer_mode_next;
			tpio_pkg::OFF_XFER: rd_val[7:0] = buffer_transfer_setting_next;
			tpio_pkg::OFF_GEN_D0: rd_val[CNT_W-1:0] = general_reg_d_ch0_next;
			tpio_pkg::OFF_GEN_C3: rd_val[CNT_W-1:0] = general_reg_c_ch3_next;
			tpio_pkg::OFF_STATUS: begin
				rd_val[3:0] = {chan_oe_n[1], chan_pin_out[1],
					chan_oe_n[0], chan_pin_out[0]};
			end
			default: rd_val = tpio_pkg::RD_ZERO;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			hrdata <= rd_val;
		end
	end

	// zero wait states, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= tpio_pkg::HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp <= tpio_pkg::HRESP_OKAY;
		end
	end

	// channel wiring: index 0 is ch0 pin d, index 1 is ch3 pin c
	assign chan_sel[0] = timer_io_control_next[tpio_pkg::CH0_FLD_LSB +:
		tpio_pkg::FLD_W];
	assign chan_sel[1] = timer_io_control_next[tpio_pkg::CH3_FLD_LSB +:
		tpio_pkg::FLD_W];
	assign chan_buf[0] = timer_mode_next[tpio_pkg::MODE_BUF_B_BIT];
	assign chan_buf[1] = timer_mode_next[tpio_pkg::MODE_BUF_A_BIT];
	assign chan_match = {cmp_match_ch3_c, cmp_match_ch0_d};
	assign chan_pin_in = {timer_pin_ch3_c_in, timer_pin_ch0_d_in};
	assign chan_ch1 = {1'b0, counter_ch1_tick};

	genvar gi;
	generate
		for (gi = 0; gi < tpio_pkg::NUM_CH; gi++) begin : g_chan
			tpio_chan #(
				.HAS_CH1_SRC(gi == 0)
			) u_chan (
				.hclk(hclk),
				.hresetn(hresetn),
				.io_sel(chan_sel[gi]),
				.io_load(wr_io),
				.buf_mode(chan_buf[gi]),
				.cmp_match(chan_match[gi]),
				.ch1_count(chan_ch1[gi]),
				.pin_in(chan_pin_in[gi]),
				.pin_out(chan_pin_out[gi]),
				.pin_oe_n(chan_oe_n[gi]),
				.cap_hit(chan_cap[gi])
			);
		end
	endgenerate

	assign timer_pin_ch0_d_out = chan_pin_out[0];
	assign timer_pin_ch0_d_oe_n = chan_oe_n[0];
	assign timer_pin_ch3_c_out = chan_pin_out[1];
	assign timer_pin_ch3_c_oe_n = chan_oe_n[1];

	a_cap_loads_d0: assert property (@(posedge hclk) disable iff (!hresetn)
		chan_cap[0] |=> general_reg_d_ch0_reg == $past(counter_ch0))
		else $error("ch0 capture did not load counter");
	a_cap_loads_c3: assert property (@(posedge hclk) disable iff (!hresetn)
		chan_cap[1] |=> general_reg_c_ch3_reg == $past(counter_ch3))
		else $error("ch3 capture did not load counter");
	a_ch1_source: assert property (@(posedge hclk) disable iff (!hresetn)
		(chan_sel[0][3:2] == 2'h3 && !chan_buf[0])
		|-> chan_cap[0] == counter_ch1_tick)
		else $error("ch1 count source not followed");
	a_ch3_no_src: assert property (@(posedge hclk) disable iff (!hresetn)
		(chan_sel[1][3:2] == 2'h3 && !chan_buf[1] && counter_ch1_tick &&
		timer_pin_ch3_c_in == $past(timer_pin_ch3_c_in))
		|-> !chan_cap[1])
		else $error("ch3 took ch1 count as capture");
	a_xfer_write: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_xfer |=> buffer_transfer_setting_reg ==
		{6'h00, $past(hwdata[1:0])})
		else $error("transfer setting write wrong");
	a_xfer_readback: assert property (@(posedge hclk) disable iff (!hresetn)
		(addr_ok && !hwrite && haddr[7:0] == tpio_pkg::OFF_XFER)
		|=> hrdata == {24'h00_0000,
		$past(buffer_transfer_setting_next)})
		else $error("transfer setting readback wrong");
	a_xfer_field_out: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_xfer ##1 !wr_xfer [*2] |-> transfer_enable_field ==
		$past(hwdata[1:0], 2))
		else $error("transfer enable output wrong");
	a_buf_no_cap: assert property (@(posedge hclk) disable iff (!hresetn)
		chan_buf[0] && !wr_gen_d0 |=> $stable(general_reg_d_ch0_reg))
		else $error("buffered register captured");
	c_cap_d0: cover property (@(posedge hclk) disable iff (!hresetn)
		chan_cap[0]);
	c_ch1_src: cover property (@(posedge hclk) disable iff (!hresetn)
		chan_sel[0][3:2] == 2'h3 && chan_cap[0]);
	c_rd_after_wr: cover property (@(posedge hclk) disable iff (!hresetn)
		wr_xfer && addr_ok && !hwrite);
endmodule

// *** tb/tpio_far_model.sv ***
`timescale 1ns/1ps
// far side: pin wires, timer counters and the ch1 count pulse
module tpio_far_model #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// device pin drive
	input wire logic d_out,
	input wire logic d_oe_n,
	input wire logic c_out,
	input wire logic c_oe_n,
	// external sources
	input wire logic d_ext,
	input wire logic c_ext,
	// resolved pins and counters
	output logic d_in,
	output logic c_in,
	output logic [CNT_W-1:0] cnt0,
	output logic [CNT_W-1:0] cnt3,
	output logic ch1_tick
);
	// device owns the wire while it drives, else the outside source
	assign d_in = d_oe_n ? d_ext : d_out;
	assign c_in = c_oe_n ? c_ext : c_out;
	// one ch1 count every eight cycles, so captures end in 7
	assign ch1_tick = (cnt0[2:0] == 3'h7);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt0 <= '0;
			cnt3 <= '0;
		end else begin
			cnt0 <= cnt0 + 1'b1;
			cnt3 <= cnt3 - 1'b1;
		end
	end
endmodule

// *** tb/timer_pin_io_control_tb.sv ***
`timescale 1ns/1ps
module timer_pin_io_control_tb;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0] htrans = 0, tef;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, m_d = 0, m_c = 0, x_d = 0, x_c = 0;
	logic d_in, c_in, d_out, d_oe_n, c_out, c_oe_n, tick;
	logic [15:0] cnt0, cnt3, e0, e3;
	logic [3:0] codes [8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h0, 4'h4};
	logic lvl;
	int n_fail = 0, checks_done = 0, cyc = 0;
	always #20 hclk = ~hclk;
	tpio_top #(.CNT_W(16)) i_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.counter_ch0(cnt0), .counter_ch3(cnt3), .cmp_match_ch0_d(m_d),
		.cmp_match_ch3_c(m_c), .counter_ch1_tick(tick),
		.timer_pin_ch0_d_in(d_in), .timer_pin_ch0_d_out(d_out),
		.timer_pin_ch0_d_oe_n(d_oe_n), .timer_pin_ch3_c_in(c_in),
		.timer_pin_ch3_c_out(c_out), .timer_pin_ch3_c_oe_n(c_oe_n),
		.transfer_enable_field(tef));
	tpio_far_model #(.CNT_W(16)) i_far (.hclk(hclk), .hresetn(hresetn),
		.d_out(d_out), .d_oe_n(d_oe_n), .c_out(c_out), .c_oe_n(c_oe_n),
		.d_ext(x_d), .c_ext(x_c), .d_in(d_in), .c_in(c_in),
		.cnt0(cnt0), .cnt3(cnt3), .ch1_tick(tick));
	task automatic check(input string nm, input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	// address phase held until hready, then data phase until hready
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1;
		haddr <= {24'h0000_00, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= w ? d : 32'h0000_0000;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
		check("hresp", {31'h0, hresp}, 32'h0000_0000);
	endtask
	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] exp);
		bus(0, a, 0);
		check(nm, q, exp);
	endtask
	// pin levels checked once the edge's updates have landed
	task automatic pins(input logic d, c, oe);
		#1;
		check("pin d", {d_oe_n, d_out}, {oe, d});
		check("pin c", {c_oe_n, c_out}, {oe, c});
		@(posedge hclk);
	endtask
	task automatic pulse();
		m_d <= 1;
		m_c <= 1;
		@(posedge hclk);
		m_d <= 0;
		m_c <= 0;
	endtask
	task automatic pin_edge(input logic v);
		x_d <= v;
		x_c <= v;
		@(posedge hclk);
		e0 = cnt0;
		e3 = cnt3;
		@(posedge hclk);
	endtask
	function automatic logic nxt(input logic [3:0] c, input logic p);
		case (c[1:0])
			2'h0: nxt = p;
			2'h1: nxt = 1'b0;
			2'h2: nxt = 1'b1;
			default: nxt = ~p;
		endcase
	endfunction
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		pins(0, 0, 0);
		check("tef rst", {30'h0, tef}, 32'h0000_0000);
		rd("xfer rst", tpio_pkg::OFF_XFER, 32'h0000_0000);
		rd("io rst", tpio_pkg::OFF_IO_CTRL, 32'h0000_0000);
		rd("status rst", tpio_pkg::OFF_STATUS, 32'h0000_0000);
		bus(1, tpio_pkg::OFF_XFER, 32'hFFFF_FFFF);
		rd("xfer ones", tpio_pkg::OFF_XFER, 32'h0000_0003);
		check("tef ones", {30'h0, tef}, 32'h0000_0003);
		bus(1, tpio_pkg::OFF_XFER, 32'h0000_0002);
		rd("xfer two", tpio_pkg::OFF_XFER, 32'h0000_0002);
		bus(1, 8'h40, 32'h0000_00FF);
		rd("unmapped", 8'h40, 32'h0000_0000);
		$display("register test done");
		lvl = 0;
		foreach (codes[i]) begin
			bus(1, tpio_pkg::OFF_IO_CTRL, {24'h0000_00, codes[i], codes[i]});
			if (codes[i][1:0] != 2'h0) lvl = codes[i][2];
			pins(lvl, lvl, 0);
			repeat (2) begin
				pulse();
				lvl = nxt(codes[i], lvl);
				pins(lvl, lvl, 0);
			end
		end
		bus(1, tpio_pkg::OFF_MODE, 32'h0000_0003);
		bus(1, tpio_pkg::OFF_IO_CTRL, {24'h0000_00, 8'h33});
		pins(lvl, lvl, 0);
		pulse();
		pins(lvl, lvl, 0);
		$display("compare test done");
		for (int i = 0; i < 4; i++) begin
			// mode first: a field write under buffer mode leaves oe alone
			bus(1, tpio_pkg::OFF_MODE, (i == 3) ? 32'h1 : 32'h0);
			bus(1, tpio_pkg::OFF_IO_CTRL, {24'h0000_00,
				(i == 0) ? 4'hC : {2'b10, i[1:0]}, {2'b10, i[1:0]}});
			pins(d_out, c_out, 1);
			bus(1, tpio_pkg::OFF_GEN_D0, 32'h0000_AAAA);
			bus(1, tpio_pkg::OFF_GEN_C3, 32'h0000_5555);
			pin_edge(1);
			rd("rise d", tpio_pkg::OFF_GEN_D0, (i == 0 || i == 2) ?
				{16'h0, e0} : 32'h0000_AAAA);
			rd("rise c", tpio_pkg::OFF_GEN_C3, (i != 1) ?
				{16'h0, e3} : 32'h0000_5555);
			// reload so a rise capture cannot stand in for a fall one
			bus(1, tpio_pkg::OFF_GEN_D0, 32'h0000_AAAA);
			bus(1, tpio_pkg::OFF_GEN_C3, 32'h0000_5555);
			pin_edge(0);
			rd("fall d", tpio_pkg::OFF_GEN_D0, (i == 1 || i == 2) ?
				{16'h0, e0} : 32'h0000_AAAA);
			rd("fall c", tpio_pkg::OFF_GEN_C3, (i != 0) ?
				{16'h0, e3} : 32'h0000_5555);
		end
		$display("capture test done");
		bus(1, tpio_pkg::OFF_MODE, 32'h0000_0000);
		bus(1, tpio_pkg::OFF_IO_CTRL, 32'h0000_008C);
		bus(1, tpio_pkg::OFF_GEN_D0, 32'h0000_AAAA);
		repeat (12) @(posedge hclk);
		bus(0, tpio_pkg::OFF_GEN_D0, 0);
		check("ch1 low", {29'h0, q[2:0]}, 32'h0000_0007);
		check("ch1 hit", {31'h0, q === 32'h0000_AAAA}, 32'h0);
		$display("ch1 source test done");
		end_sim();
	end
endmodule
